// ### core/valve_sp_pkg.sv
`default_nettype none

package valve_sp_pkg;

    localparam int ADDR_W = 9;

    // register byte offsets
    localparam logic [8:0] OFS_CFG        = 9'h000;
    localparam logic [8:0] OFS_DEADBAND   = 9'h004;
    localparam logic [8:0] OFS_CUT_LOW    = 9'h008;
    localparam logic [8:0] OFS_CUT_HIGH   = 9'h00C;
    localparam logic [8:0] OFS_CTRL       = 9'h010;
    localparam logic [8:0] OFS_STATUS     = 9'h014;
    localparam logic [8:0] OFS_SPAN       = 9'h018;
    localparam logic [8:0] OFS_ZERO       = 9'h01C;
    localparam logic [8:0] OFS_OVERSTROKE = 9'h020;
    localparam logic [8:0] OFS_WSP        = 9'h024;
    localparam logic [8:0] OFS_DRIVE      = 9'h028;
    localparam logic [8:0] OFS_PID_BASE   = 9'h040;
    localparam logic [8:0] OFS_X_BASE     = 9'h100;
    localparam logic [8:0] OFS_Y_BASE     = 9'h180;

    // configuration field positions
    localparam int CFG_CLOSED_UP  = 0;
    localparam int CFG_LEVER_UP   = 1;
    localparam int CFG_REVERSE    = 2;
    localparam int CFG_DOUBLE     = 3;
    localparam int CFG_CHAR_LSB   = 4;
    localparam int CFG_SIZE_LSB   = 6;
    localparam int CFG_FRIC_LSB   = 10;
    localparam int CTRL_START_CAL = 0;

    // percent values in hundredths of a percent
    localparam logic signed [15:0] PCT_FULL      = 16'sh2710;
    localparam logic signed [15:0] PCT_ONE       = 16'sh0064;
    localparam logic signed [15:0] PCT_HYST      = 16'sh000A;
    localparam logic signed [15:0] CUT_LOW_MIN   = -16'sh4E20;
    localparam logic signed [15:0] CUT_MID       = 16'sh1388;
    localparam logic signed [15:0] CUT_HIGH_MAX  = 16'sh4E20;
    localparam logic signed [15:0] RST_CUT_LOW   = 16'sh0064;
    localparam logic signed [15:0] RST_CUT_HIGH  = 16'sh26AC;
    localparam logic signed [15:0] RST_DEADBAND  = 16'sh0032;
    localparam logic signed [15:0] RST_OVERSTRK  = 16'sh2774;
    localparam logic signed [15:0] CURVE_STEP    = 16'sh01F4;
    localparam logic [15:0]        TI_OFF        = 16'h270F;
    localparam logic [11:0]        RST_CFG       = 12'h000;

    localparam int NPTS   = 21;
    localparam int NPARAM = 11;
    localparam int NSIZE  = 9;
    localparam logic [3:0] SIZE_CUSTOM = 4'h9;
    localparam int KP_SHIFT = 8;
    localparam logic signed [63:0] ACC_LIM = 64'sh0000_0000_000F_4240;

    // control loop period and settle time
    localparam int CLK_MHZ       = 100;
    localparam int CTRL_PERIOD_US = 1000;
    localparam int TICK_CYCLES   = CTRL_PERIOD_US * CLK_MHZ;
    localparam int SETTLE_TICKS  = 3000;

    typedef logic signed [15:0] pct_t;

    typedef enum logic [1:0] {CH_LINEAR, CH_EQUAL, CH_QUICK, CH_CUSTOM} charact_t;
    typedef enum logic [1:0] {FR_LIGHT, FR_MEDIUM, FR_HEAVY, FR_SPARE} friction_t;
    typedef enum logic [1:0] {CAL_IDLE, CAL_CLOSE1, CAL_OPEN, CAL_CLOSE2} cal_state_t;

    // order matches the eleven custom parameter words
    typedef struct packed {
        logic [15:0] kp_out;
        logic [15:0] ti_out;
        logic [15:0] td_out;
        pct_t        gap;
        logic [15:0] kp_in;
        logic [15:0] ti_in;
        logic [15:0] td_in;
        pct_t        dual;
        logic [15:0] kp_dual;
        logic [15:0] ti_dual;
        logic [15:0] td_dual;
    } pid_set_t;

    typedef struct packed {
        logic signal_loss_fail_direction;
        logic supply_loss_fail_direction;
        logic supply_loss_shown;
        logic forced_close;
        logic forced_open;
        logic cal_busy;
        logic setup_done;
    } status_t;

    // presets: index 0..5 numbered, 6..8 lettered
    localparam logic [15:0] PRESET_KP [NSIZE] =
        '{16'h0300, 16'h0200, 16'h0180, 16'h0100, 16'h00C0, 16'h0080,
          16'h0400, 16'h0500, 16'h0600};
    localparam logic [15:0] PRESET_TI [NSIZE] =
        '{16'h0064, 16'h00C8, 16'h0190, 16'h0258, 16'h0320, 16'h03E8,
          16'h0050, 16'h0040, 16'h0030};

endpackage : valve_sp_pkg

`default_nettype wire

// ### core/valve_setpoint_and_gap_pid.sv
// Functional notes
// - signal-loss direction from closed, lever, action
// - supply-loss direction from closed and lever
// - hide supply-loss direction for double acting
// - parameter set from size preset and friction
// - custom size ignores friction level
// - custom parameters writable only when size custom
// - eleven parameters, three gap-selected sets
// - integral time 9999 disables integral
// - linear, equal percent, quick open, custom
// - custom curve interpolates 21 point pairs
// - points clamped 0..100, linear outside
// - input at or below low forces close
// - input at or above high forces open
// - equal thresholds give on/off operation
// - clamp low -200..50, high 50..200
// - 0.1 percent hysteresis before release
// - working setpoint shows forced end value
// - span change rewrites high to overstroke-1; code does so only once setup is done
// - auto calibration close-open-close, store points
//
// Local design decisions: the address map and the strobed register port.
`default_nettype none

module valve_setpoint_and_gap_pid #(
    parameter int TICK_CYCLES  = valve_sp_pkg::TICK_CYCLES,
    parameter int SETTLE_TICKS = valve_sp_pkg::SETTLE_TICKS
) (
    input  wire logic                        i_clock,
    input  wire logic                        i_arst_n,
    input  wire logic [8:0]                  i_addr,
    input  wire logic [31:0]                 i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [31:0]                 o_rdata,
    input  wire valve_sp_pkg::pct_t          i_input_pct,
    input  wire valve_sp_pkg::pct_t          i_travel_pct,
    input  wire logic [15:0]                 i_travel_raw,
    output valve_sp_pkg::pct_t               o_working_sp,
    output valve_sp_pkg::pct_t               o_drive,
    output logic      [15:0]                 o_zero_point,
    output logic      [15:0]                 o_span_point,
    output valve_sp_pkg::status_t            o_status
);
    import valve_sp_pkg::*;

    if (TICK_CYCLES < 2 || SETTLE_TICKS < 1) begin : g_bad
        $error("bad timing parameters");
    end

    logic rst_meta_r, rst_n_r;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    function automatic logic signed [63:0] sx(input pct_t v);
        sx = {{48{v[15]}}, v};
    endfunction : sx

    function automatic logic signed [63:0] ux(input logic [15:0] v);
        ux = {48'h0, v};
    endfunction : ux

    function automatic pct_t clampp(input logic signed [63:0] v, input pct_t lo, input pct_t hi);
        if (v < sx(lo)) clampp = lo;
        else if (v > sx(hi)) clampp = hi;
        else clampp = v[15:0];
    endfunction : clampp

    // register file
    logic [11:0]  cfg_r;
    pct_t         deadband_r, cut_low_r, cut_high_r, overstroke_r;
    logic [15:0]  pid_r [NPARAM];
    pct_t         x_r [NPTS];
    pct_t         y_r [NPTS];
    logic         setup_done_r;
    logic [15:0]  zero_r, span_r;
    logic         cal_start;
    logic         cal_done;
    logic [15:0]  cal_open_r;

    charact_t  char_mode;
    logic [3:0] size_sel;
    friction_t fric;
    assign char_mode = charact_t'(cfg_r[CFG_CHAR_LSB +: 2]);
    assign size_sel  = cfg_r[CFG_SIZE_LSB +: 4];
    assign fric      = friction_t'(cfg_r[CFG_FRIC_LSB +: 2]);

    pct_t wr_pct;
    logic [8:0] pid_ofs, x_ofs, y_ofs;
    assign wr_pct  = i_wdata[15:0];
    assign pid_ofs = i_addr - OFS_PID_BASE;
    assign x_ofs   = i_addr - OFS_X_BASE;
    assign y_ofs   = i_addr - OFS_Y_BASE;

    logic span_write;
    assign span_write = i_wr && i_addr == OFS_SPAN;
    assign cal_start  = i_wr && i_addr == OFS_CTRL && i_wdata[CTRL_START_CAL];

    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cfg_r        <= RST_CFG;
            deadband_r   <= RST_DEADBAND;
            cut_low_r    <= RST_CUT_LOW;
            overstroke_r <= RST_OVERSTRK;
        end else if (i_wr) begin
            case (i_addr)
                OFS_CFG:        cfg_r        <= i_wdata[11:0];
                OFS_DEADBAND:   deadband_r   <= clampp(sx(wr_pct), '0, PCT_FULL);
                OFS_CUT_LOW:    cut_low_r    <= clampp(sx(wr_pct), CUT_LOW_MIN, CUT_MID);
                OFS_OVERSTROKE: overstroke_r <= wr_pct;
                default: ;
            endcase
        end
    end

    // rewritten on a span change once setup has run
    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cut_high_r <= RST_CUT_HIGH;
        end else if ((span_write || cal_done) && setup_done_r) begin
            cut_high_r <= clampp(sx(overstroke_r) - sx(PCT_ONE), CUT_MID, CUT_HIGH_MAX);
        end else if (i_wr && i_addr == OFS_CUT_HIGH) begin
            cut_high_r <= clampp(sx(wr_pct), CUT_MID, CUT_HIGH_MAX);
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            for (int k = 0; k < NPARAM; k++) pid_r[k] <= '0;
        end else if (i_wr && size_sel == SIZE_CUSTOM && pid_ofs[1:0] == 2'b00
                     && pid_ofs[8:2] < 7'(NPARAM)) begin
            pid_r[pid_ofs[5:2]] <= i_wdata[15:0];
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            for (int k = 0; k < NPTS; k++) begin
                x_r[k] <= 16'(CURVE_STEP * k);
                y_r[k] <= 16'(CURVE_STEP * k);
            end
        end else if (i_wr && x_ofs[1:0] == 2'b00 && x_ofs[8:2] < 7'(NPTS)) begin
            x_r[x_ofs[6:2]] <= clampp(sx(wr_pct), '0, PCT_FULL);
        end else if (i_wr && y_ofs[1:0] == 2'b00 && y_ofs[8:2] < 7'(NPTS)) begin
            y_r[y_ofs[6:2]] <= clampp(sx(wr_pct), '0, PCT_FULL);
        end
    end

    // parameter set selection
    pid_set_t preset_set, act_set;
    always_comb begin
        logic [3:0]  idx;
        logic [15:0] kp;
        pct_t        gap;
        idx = (size_sel < 4'(NSIZE)) ? size_sel : 4'h0;
        kp  = PRESET_KP[idx];
        case (fric)
            FR_HEAVY:  gap = 16'sh0064;
            FR_MEDIUM: gap = 16'sh0096;
            default:   gap = 16'sh00C8;
        endcase
        preset_set = '{kp_out: kp, ti_out: PRESET_TI[idx], td_out: 16'h0001, gap: gap,
                       kp_in: kp >> 1, ti_in: PRESET_TI[idx], td_in: 16'h0000,
                       dual: gap >>> 2, kp_dual: kp >> 2, ti_dual: TI_OFF,
                       td_dual: 16'h0000};
        // custom words ignore the friction field entirely
        act_set = (size_sel == SIZE_CUSTOM) ?
            {pid_r[0], pid_r[1], pid_r[2], pid_r[3], pid_r[4], pid_r[5],
              pid_r[6], pid_r[7], pid_r[8], pid_r[9], pid_r[10]} : preset_set;
    end

    // fail directions, high means fails open
    status_t stat;
    always_comb begin
        stat = '0;
        stat.supply_loss_fail_direction = (cfg_r[CFG_CLOSED_UP] ^ cfg_r[CFG_LEVER_UP])
                                          & ~cfg_r[CFG_DOUBLE];
        stat.signal_loss_fail_direction = cfg_r[CFG_CLOSED_UP] ^ cfg_r[CFG_LEVER_UP]
                                          ^ cfg_r[CFG_REVERSE];
        stat.supply_loss_shown = ~cfg_r[CFG_DOUBLE];
    end

    // characterization
    pct_t char_out;
    always_comb begin
        logic signed [63:0] xin, full, dx, dy, seg_y;
        int seg;
        xin   = sx(i_input_pct);
        full  = sx(PCT_FULL);
        seg   = 0;
        dx    = '0;
        dy    = '0;
        seg_y = '0;
        for (int k = 1; k < NPTS - 1; k++) begin
            if (i_input_pct >= x_r[k]) seg = k;
        end
        if (i_input_pct < 16'sh0000 || i_input_pct > PCT_FULL) begin
            char_out = i_input_pct;
        end else begin
            case (char_mode)
                CH_EQUAL: char_out = 16'((xin * xin) / full);
                CH_QUICK: char_out = 16'(full - ((full - xin) * (full - xin)) / full);
                CH_CUSTOM: begin
                    dx    = sx(x_r[seg + 1]) - sx(x_r[seg]);
                    dy    = sx(y_r[seg + 1]) - sx(y_r[seg]);
                    seg_y = sx(y_r[seg]);
                    if (i_input_pct < x_r[0]) char_out = i_input_pct;
                    else if (i_input_pct > x_r[NPTS - 1]) char_out = i_input_pct;
                    else if (dx <= 0) char_out = y_r[seg];
                    else char_out = 16'(seg_y + ((xin - sx(x_r[seg])) * dy) / dx);
                end
                default: char_out = i_input_pct;
            endcase
        end
    end

    // forced cutoffs with hysteresis
    logic fclose_r, fopen_r;
    logic signed [63:0] in_w;
    assign in_w = sx(i_input_pct);
    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fclose_r <= 1'b0;
            fopen_r  <= 1'b0;
        end else if (cut_low_r == cut_high_r) begin
            // single threshold: on/off with the same release margin
            if (in_w >= sx(cut_high_r)) fopen_r <= 1'b1;
            else if (in_w < sx(cut_high_r) - sx(PCT_HYST)) fopen_r <= 1'b0;
            fclose_r <= !((in_w >= sx(cut_high_r)) ||
                          (fopen_r && in_w >= sx(cut_high_r) - sx(PCT_HYST)));
        end else begin
            if (in_w <= sx(cut_low_r)) fclose_r <= 1'b1;
            else if (in_w > sx(cut_low_r) + sx(PCT_HYST)) fclose_r <= 1'b0;
            if (in_w >= sx(cut_high_r)) fopen_r <= 1'b1;
            else if (in_w < sx(cut_high_r) - sx(PCT_HYST)) fopen_r <= 1'b0;
        end
    end

    pct_t wsp_r;
    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) wsp_r <= '0;
        else if (fclose_r) wsp_r <= '0;
        else if (fopen_r) wsp_r <= PCT_FULL;
        else wsp_r <= char_out;
    end

    // control tick divider
    logic [31:0] div_r;
    logic        tick;
    assign tick = div_r == 32'(TICK_CYCLES - 1);
    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) div_r <= '0;
        else div_r <= tick ? '0 : div_r + 32'd1;
    end

    // auto travel calibration
    cal_state_t  cal_st_r;
    logic [31:0] settle_r;
    logic        settled;
    assign settled  = tick && settle_r == 32'(SETTLE_TICKS - 1);
    assign cal_done = cal_st_r == CAL_CLOSE2 && settled;
    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cal_st_r   <= CAL_IDLE;
            settle_r   <= '0;
            cal_open_r <= '0;
        end else begin
            if (tick) settle_r <= settled ? '0 : settle_r + 32'd1;
            case (cal_st_r)
                CAL_IDLE: begin
                    settle_r <= '0;
                    if (cal_start) cal_st_r <= CAL_CLOSE1;
                end
                CAL_CLOSE1: if (settled) cal_st_r <= CAL_OPEN;
                CAL_OPEN: if (settled) begin
                    cal_open_r <= i_travel_raw;
                    cal_st_r   <= CAL_CLOSE2;
                end
                CAL_CLOSE2: if (settled) cal_st_r <= CAL_IDLE;
                default: cal_st_r <= CAL_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            zero_r       <= '0;
            span_r       <= 16'hFFFF;
            setup_done_r <= 1'b0;
        end else if (cal_done) begin
            zero_r       <= i_travel_raw;
            span_r       <= cal_open_r;
            setup_done_r <= 1'b1;
        end else if (span_write) begin
            span_r <= i_wdata[15:0];
        end
    end

    // gap-scheduled controller, updated once per tick
    pct_t drive_r;
    logic signed [63:0] acc_r, err_prev_r;
    logic signed [63:0] err, mag, acc_nxt, p_t, i_t, d_t;
    logic [15:0] kp, ti, td;
    always_comb begin
        err = sx(wsp_r) - sx(i_travel_pct);
        mag = (err < 0) ? -err : err;
        if (mag > sx(act_set.gap)) begin
            kp = act_set.kp_out;
            ti = act_set.ti_out;
            td = act_set.td_out;
        end else if (mag > sx(act_set.dual)) begin
            kp = act_set.kp_in;
            ti = act_set.ti_in;
            td = act_set.td_in;
        end else begin
            kp = act_set.kp_dual;
            ti = act_set.ti_dual;
            td = act_set.td_dual;
        end
        acc_nxt = acc_r + err;
        if (acc_nxt > ACC_LIM) acc_nxt = ACC_LIM;
        if (acc_nxt < -ACC_LIM) acc_nxt = -ACC_LIM;
        if (ti == TI_OFF || ti == 16'h0000) acc_nxt = '0;
        p_t = (ux(kp) * err) >>> KP_SHIFT;
        i_t = (ti == TI_OFF || ti == 16'h0000) ? '0
              : ((ux(kp) * acc_nxt) / ux(ti)) >>> KP_SHIFT;
        d_t = (ux(kp) * ux(td) * (err - err_prev_r)) >>> KP_SHIFT;
    end

    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            drive_r    <= '0;
            acc_r      <= '0;
            err_prev_r <= '0;
        end else if (cal_st_r == CAL_CLOSE1 || cal_st_r == CAL_CLOSE2) begin
            drive_r <= '0;
            acc_r   <= '0;
        end else if (cal_st_r == CAL_OPEN) begin
            drive_r <= PCT_FULL;
        end else if (tick && mag > sx(deadband_r)) begin
            drive_r    <= clampp(p_t + i_t + d_t, '0, PCT_FULL);
            acc_r      <= acc_nxt;
            err_prev_r <= err;
        end else if (tick) begin
            err_prev_r <= err;
        end
    end

    // read port
    status_t stat_full;
    always_comb begin
        stat_full              = stat;
        stat_full.forced_close = fclose_r;
        stat_full.forced_open  = fopen_r;
        stat_full.cal_busy     = cal_st_r != CAL_IDLE;
        stat_full.setup_done   = setup_done_r;
    end

    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = '0;
        case (i_addr)
            OFS_CFG:        rd_nxt = {20'h0, cfg_r};
            OFS_DEADBAND:   rd_nxt = {16'h0, deadband_r};
            OFS_CUT_LOW:    rd_nxt = {16'h0, cut_low_r};
            OFS_CUT_HIGH:   rd_nxt = {16'h0, cut_high_r};
            OFS_STATUS:     rd_nxt = {25'h0, stat_full};
            OFS_SPAN:       rd_nxt = {16'h0, span_r};
            OFS_ZERO:       rd_nxt = {16'h0, zero_r};
            OFS_OVERSTROKE: rd_nxt = {16'h0, overstroke_r};
            OFS_WSP:        rd_nxt = {16'h0, wsp_r};
            OFS_DRIVE:      rd_nxt = {16'h0, drive_r};
            default: begin
                if (pid_ofs[1:0] == 2'b00 && pid_ofs[8:2] < 7'(NPARAM))
                    rd_nxt = {16'h0, act_set[16*(NPARAM-1-int'(pid_ofs[5:2])) +: 16]};
                else if (x_ofs[1:0] == 2'b00 && x_ofs[8:2] < 7'(NPTS))
                    rd_nxt = {16'h0, x_r[x_ofs[6:2]]};
                else if (y_ofs[1:0] == 2'b00 && y_ofs[8:2] < 7'(NPTS))
                    rd_nxt = {16'h0, y_r[y_ofs[6:2]]};
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_rdata      <= '0;
            o_working_sp <= '0;
            o_drive      <= '0;
            o_zero_point <= '0;
            o_span_point <= '0;
            o_status     <= '0;
        end else begin
            o_rdata      <= i_rd ? rd_nxt : '0;
            o_working_sp <= wsp_r;
            o_drive      <= drive_r;
            o_zero_point <= zero_r;
            o_span_point <= span_r;
            o_status     <= stat_full;
        end
    end

endmodule : valve_setpoint_and_gap_pid

`default_nettype wire

// ### bench/valve_sp_chk.sv
`default_nettype none
module valve_sp_chk
    import valve_sp_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_arst_n,
    input wire logic [8:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire pct_t        o_working_sp,
    input wire pct_t        o_drive,
    input wire status_t     o_status
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cfg_r;
    logic [2:0] age_r;
    // age_r masks the cycles while the reset flops let go
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_r <= 4'h0;
            age_r <= 3'h0;
        end else begin
            if (i_wr && i_addr == OFS_CFG) cfg_r <= i_wdata[3:0];
            if (age_r != 3'h7) age_r <= age_r + 3'h1;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    sequence s_steady(logic [3:0] m);
        (age_r == 3'h7 && $stable(cfg_r & m)) [*3];
    endsequence
    sequence s_held(logic b);
        b [*3];
    endsequence
    a_signal_dir: assert property (
        s_steady(4'h7) |-> $stable(o_status.signal_loss_fail_direction))
        else $error("signal loss direction moved");
    a_supply_dir: assert property (
        s_steady(4'hB) |-> $stable(o_status.supply_loss_fail_direction))
        else $error("supply loss direction moved");
    a_shown_double: assert property (
        s_steady(4'h8) ##0 cfg_r[3] |-> !o_status.supply_loss_shown)
        else $error("supply loss direction shown");
    a_close_sp: assert property (
        s_held(o_status.forced_close) |-> o_working_sp == 16'sh0000)
        else $error("working setpoint not closed");
    a_open_sp: assert property (
        s_held(o_status.forced_open && !o_status.forced_close) |-> o_working_sp == PCT_FULL)
        else $error("working setpoint not open");
    a_cal_ends: assert property (
        o_status.cal_busy [*8] |-> o_drive == 16'sh0000 || o_drive == PCT_FULL)
        else $error("calibration drive not at an end");
    a_cal_done: assert property (
        $fell(o_status.cal_busy) |-> ##[0:1] o_status.setup_done) else $error("no setup done");
    a_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 32'h0000_0000) else $error("read data without read");
endmodule : valve_sp_chk
`default_nettype wire

// ### bench/valve_actuator_model.sv
`default_nettype none
module valve_actuator_model
    import valve_sp_pkg::*;
#(
    parameter logic [15:0] RAW_ZERO = 16'h0400
) (
    input  wire logic   i_clock,
    input  wire logic   i_arst_n,
    input  wire pct_t   i_drive,
    output pct_t        o_travel_pct,
    output logic [15:0] o_travel_raw
);
    timeunit 1ns;
    timeprecision 1ns;
    // stem follows drive one cycle late; a real stem is far slower
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) o_travel_pct <= 16'sh0000;
        else o_travel_pct <= i_drive;
    end
    assign o_travel_raw = RAW_ZERO + o_travel_pct;
endmodule : valve_actuator_model
`default_nettype wire

// ### bench/valve_setpoint_and_gap_pid_test.sv
`default_nettype none
module valve_setpoint_and_gap_pid_test import valve_sp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] RAW_ZERO = 16'h0400;
    // cfg, input, expected working setpoint
    localparam logic [43:0] ROWS [14] = '{
        44'h000_1388_1388, 44'h000_26AB_26AB, 44'h000_26AC_2710, 44'h000_26A7_2710,
        44'h000_26A1_26A1, 44'h000_0065_0065, 44'h000_0064_0000, 44'h000_0069_0000,
        44'h000_006F_006F, 44'h000_FE0C_0000, 44'h010_1388_09C4, 44'h020_1388_1D4C,
        44'h030_128E_1356, 44'h030_1388_1518};
    logic        i_clock;
    logic        i_arst_n;
    logic [8:0]  i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rdata;
    pct_t        i_input_pct;
    pct_t        travel;
    logic [15:0] travel_raw;
    pct_t        o_working_sp;
    pct_t        o_drive;
    logic [15:0] o_zero_point;
    logic [15:0] o_span_point;
    status_t     o_status;
    status_t     s0;
    int          err_total = 0;
    int          total_checks = 0;
    int          cycles = 0;
    valve_setpoint_and_gap_pid #(.TICK_CYCLES(4), .SETTLE_TICKS(2)) i_dut (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_input_pct(i_input_pct),
        .i_travel_pct(travel), .i_travel_raw(travel_raw), .o_working_sp(o_working_sp),
        .o_drive(o_drive), .o_zero_point(o_zero_point), .o_span_point(o_span_point),
        .o_status(o_status));
    valve_actuator_model #(.RAW_ZERO(RAW_ZERO)) i_act (.i_clock(i_clock), .i_arst_n(i_arst_n),
        .i_drive(o_drive), .o_travel_pct(travel), .o_travel_raw(travel_raw));
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_addr  <= a;
        i_wdata <= {16'h0000, d};
        i_wr    <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [15:0] exp);
        @(posedge i_clock);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        check($sformatf("reg %h", a), o_rdata, {16'h0000, exp});
    endtask : rd
    task automatic sp(input pct_t inp, exp);
        @(posedge i_clock);
        i_input_pct <= inp;
        repeat (5) @(negedge i_clock);
        check("working sp", 32'(o_working_sp), 32'(exp));
    endtask : sp
    task automatic give_verdict();
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        i_arst_n    = 1'b0;
        i_addr      = 9'h000;
        i_wdata     = 32'h0000_0000;
        i_wr        = 1'b0;
        i_rd        = 1'b0;
        i_input_pct = 16'sh1388;
        repeat (5) @(negedge i_clock);
        check("reset drive", 32'(o_drive), 32'h0000_0000);
        check("reset status", 32'(o_status), 32'h0000_0000);
        @(posedge i_clock);
        i_arst_n <= 1'b1;
        repeat (2) @(posedge i_clock);
        rd(OFS_DEADBAND, RST_DEADBAND);
        rd(OFS_CUT_LOW, RST_CUT_LOW);
        rd(OFS_CUT_HIGH, RST_CUT_HIGH);
        rd(9'h0FC, 16'h0000);
        wr(OFS_CFG, 16'h0000);
        repeat (4) @(negedge i_clock);
        s0 = o_status;
        wr(OFS_CFG, 16'h0004);
        repeat (4) @(negedge i_clock);
        check("signal dir", 32'(s0[6] ^ o_status[6]), 32'h1);
        check("supply dir", 32'(o_status[5]), 32'(s0[5]));
        check("supply shown", 32'(o_status[4]), 32'h1);
        wr(OFS_CFG, 16'h0008);
        repeat (4) @(negedge i_clock);
        check("supply hidden", 32'(o_status[4]), 32'h0);
        wr(OFS_Y_BASE + 9'h028, 16'h1518);
        foreach (ROWS[k]) begin
            wr(OFS_CFG, {4'h0, ROWS[k][43:32]});
            sp(ROWS[k][31:16], ROWS[k][15:0]);
        end
        wr(OFS_CUT_LOW, 16'h8AD0);
        rd(OFS_CUT_LOW, CUT_LOW_MIN);
        wr(OFS_CUT_HIGH, 16'h03E8);
        rd(OFS_CUT_HIGH, CUT_MID);
        wr(OFS_CUT_LOW, 16'h2710);
        rd(OFS_CUT_LOW, CUT_MID);
        sp(16'sh1770, PCT_FULL);
        sp(16'sh0FA0, 16'sh0000);
        wr(OFS_Y_BASE + 9'h050, 16'h4E20);
        rd(OFS_Y_BASE + 9'h050, PCT_FULL);
        wr(OFS_CFG, 16'h0000);
        wr(OFS_PID_BASE, 16'h1234);
        rd(OFS_PID_BASE, PRESET_KP[0]);
        wr(OFS_CFG, 16'h0240);
        wr(OFS_PID_BASE + 9'h0C, 16'h00FA);
        rd(OFS_PID_BASE, 16'h0000);
        wr(OFS_CFG, 16'h0A40);
        rd(OFS_PID_BASE + 9'h0C, 16'h00FA);
        wr(OFS_CTRL, 16'h0001);
        for (int n = 0; n < 400 && o_status.setup_done !== 1'b1; n++)
            @(negedge i_clock);
        check("setup done", 32'(o_status.setup_done), 32'h1);
        check("zero point", 32'(o_zero_point), 32'(RAW_ZERO));
        check("span point", 32'(o_span_point), 32'(RAW_ZERO + 16'h2710));
        rd(OFS_CUT_HIGH, CUT_MID);
        wr(OFS_SPAN, 16'h2000);
        rd(OFS_CUT_HIGH, RST_OVERSTRK - PCT_ONE);
        give_verdict();
    end
endmodule : valve_setpoint_and_gap_pid_test
bind valve_setpoint_and_gap_pid valve_sp_chk i_chk (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_working_sp(o_working_sp), .o_drive(o_drive), .o_status(o_status));
`default_nettype wire
